/* design/sbl_binload.sv */
// console binary load/unload command handler with two-entry transmit buffer
`include "sbl_map.svh"

module sbl_binload #(
    parameter logic [31:0] TIMEOUT_CYC = 32'(`SBL_TIMEOUT_S * `SBL_CLK_HZ)
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // received serial bytes
    input wire logic rxValid,
    input wire sbl_pkg::sbl_rx_t rxByte,
    output logic rxReady,
    // transmitted serial bytes
    output logic txValid,
    output logic [7:0] txData,
    input wire logic txReady,
    // memory port
    output logic memReqValid,
    output sbl_pkg::sbl_mem_req_t memReqBits,
    input wire logic memAck,
    input wire logic memErr,
    input wire logic [7:0] memRdata,
    // status
    output logic busy
);
    import sbl_pkg::*;

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] hexVal(input logic [7:0] c);
        if (c >= `SBL_CH_0 && c <= `SBL_CH_9) begin
            return {1'b1, 4'(c - `SBL_CH_0)};
        end else if (c >= `SBL_CH_UA && c <= `SBL_CH_UF) begin
            return {1'b1, 4'(c - `SBL_CH_UA + `SBL_HEX_TEN)};
        end else if (c >= `SBL_CH_LA && c <= `SBL_CH_LF_HEX) begin
            return {1'b1, 4'(c - `SBL_CH_LA + `SBL_HEX_TEN)};
        end
        return 5'h00;
    endfunction

    function automatic logic [7:0] msgChar(input sbl_msg_t sel, input logic [3:0] idx);
        if (sel == SBL_MSG_PROMPT) begin
            return `SBL_CH_GT;
        end
        case (idx)
            4'h0: return `SBL_CH_QM;
            4'h1: return `SBL_CH_E;
            4'h2, 4'h3: return `SBL_CH_R;
            4'h4: return `SBL_CH_CR;
            4'h5: return `SBL_CH_LF;
            default: return `SBL_CH_GT;
        endcase
    endfunction

    function automatic logic isUnload(input sbl_state_t s);
        return s == SBL_ST_ULRD || s == SBL_ST_ULSEND || s == SBL_ST_ULSUM;
    endfunction

    // ------------------------------------------------------------------
    // transmit buffer
    // ------------------------------------------------------------------
    logic pushValid;
    logic pushReady;
    logic [7:0] pushData;
    logic [7:0] bufReg [2];
    logic [7:0] bufNext [2];
    logic wrPtrReg, wrPtrNext, rdPtrReg, rdPtrNext;
    logic [1:0] fillReg, fillNext;
    logic [7:0] txDataNext;

    // transmitter stall (txReady low) holds bytes here instead of losing them
    assign pushReady = fillReg != 2'h2;
    assign txValid = fillReg != 2'h0;

    always_comb begin
        logic push;
        logic pop;
        push = pushValid && pushReady;
        pop = txValid && txReady;
        wrPtrNext = push ? ~wrPtrReg : wrPtrReg;
        rdPtrNext = pop ? ~rdPtrReg : rdPtrReg;
        fillNext = 2'(fillReg + {1'b0, push} - {1'b0, pop});
        for (int i = 0; i < 2; i++) begin
            bufNext[i] = (push && wrPtrReg == 1'(i)) ? pushData : bufReg[i];
        end
        txDataNext = bufNext[rdPtrNext];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtrReg <= 1'b0;
            rdPtrReg <= 1'b0;
            fillReg <= 2'h0;
            bufReg[0] <= 8'h00;
            bufReg[1] <= 8'h00;
            txData <= 8'h00;
        end else begin
            wrPtrReg <= wrPtrNext;
            rdPtrReg <= rdPtrNext;
            fillReg <= fillNext;
            bufReg <= bufNext;
            txData <= txDataNext;
        end
    end

    // ------------------------------------------------------------------
    // command and transfer sequencer
    // ------------------------------------------------------------------
    sbl_state_t stateReg, stateNext, retReg, retNext;
    sbl_msg_t msgSelReg, msgSelNext;
    logic [3:0] msgIdxReg, msgIdxNext;
    logic [1:0] fieldReg, fieldNext, kindReg, kindNext;
    logic lineOkReg, lineOkNext;
    logic [7:0] lastChReg, lastChNext, sumReg, sumNext, dataReg, dataNext;
    logic [31:0] addrReg, addrNext, cntReg, cntNext, tmrReg, tmrNext;
    logic [30:0] remReg, remNext;
    logic errReg, errNext, pausedReg, pausedNext, suppReg, suppNext;
    logic rxFire, waiting, timeout;
    logic [7:0] rxD;
    logic [7:0] ckSum;

    assign rxD = rxByte.data;
    assign rxFire = rxValid && rxReady;
    assign ckSum = 8'(sumReg + rxD);
    assign waiting = stateReg == SBL_ST_CKSUM || stateReg == SBL_ST_LOAD
        || stateReg == SBL_ST_LDSUM;
    assign timeout = waiting && tmrReg >= TIMEOUT_CYC - 32'h1;
    assign busy = stateReg != SBL_ST_LINE;
    assign memReqValid = stateReg == SBL_ST_LDWR || stateReg == SBL_ST_ULRD;
    assign memReqBits = '{we: stateReg == SBL_ST_LDWR, addr: addrReg, wdata: dataReg};

    always_comb begin
        case (stateReg)
            SBL_ST_LINE: rxReady = pushReady;
            SBL_ST_MSG, SBL_ST_LDWR: rxReady = 1'b0;
            default: rxReady = 1'b1;
        endcase
    end

    always_comb begin
        logic startMsg;
        logic [4:0] hv;
        logic advance;
        sbl_msg_t startSel;
        sbl_state_t startRet;
        startMsg = 1'b0;
        startSel = SBL_MSG_PROMPT;
        startRet = SBL_ST_LINE;
        advance = 1'b0;
        hv = hexVal(rxD);
        stateNext = stateReg;
        retNext = retReg;
        msgSelNext = msgSelReg;
        msgIdxNext = msgIdxReg;
        fieldNext = fieldReg;
        kindNext = kindReg;
        lineOkNext = lineOkReg;
        lastChNext = lastChReg;
        sumNext = sumReg;
        dataNext = dataReg;
        addrNext = addrReg;
        cntNext = cntReg;
        remNext = remReg;
        errNext = errReg;
        pausedNext = pausedReg;
        suppNext = suppReg;
        pushValid = 1'b0;
        pushData = rxD;
        tmrNext = (waiting && !rxFire) ? tmrReg + 32'h1 : 32'h0;
        case (stateReg)
            SBL_ST_LINE: begin
                if (rxFire) begin
                    if (rxD == `SBL_CH_CR) begin
                        pausedNext = 1'b0;
                        fieldNext = `SBL_FIELD_CMD;
                        lineOkNext = 1'b0;
                        kindNext = `SBL_KIND_NONE;
                        if (lineOkReg && fieldReg == `SBL_FIELD_CNT) begin
                            stateNext = SBL_ST_CKSUM;
                        end else begin
                            sumNext = 8'h00;
                            addrNext = 32'h0;
                            cntNext = 32'h0;
                        end
                    end else if (rxD == `SBL_CH_XOFF || rxD == `SBL_CH_XON) begin
                        pausedNext = rxD == `SBL_CH_XOFF;
                    end else if (rxD == `SBL_CH_RUB) begin
                        // only the most recent character can be taken back
                        if (kindReg != `SBL_KIND_NONE) begin
                            sumNext = 8'(sumReg - lastChReg);
                        end
                        if (kindReg == `SBL_KIND_HEX && fieldReg == `SBL_FIELD_ADDR) begin
                            addrNext = addrReg >> 4;
                        end
                        if (kindReg == `SBL_KIND_HEX && fieldReg == `SBL_FIELD_CNT) begin
                            cntNext = cntReg >> 4;
                        end
                        if (kindReg == `SBL_KIND_SP) begin
                            fieldNext = 2'(fieldReg - 2'h1);
                        end
                        if (kindReg == `SBL_KIND_X) begin
                            lineOkNext = 1'b0;
                        end
                        kindNext = `SBL_KIND_NONE;
                    end else begin
                        sumNext = ckSum;
                        pushValid = 1'b1;
                        lastChNext = rxD;
                        if (fieldReg == `SBL_FIELD_CMD && !lineOkReg
                            && (rxD == `SBL_CH_XU || rxD == `SBL_CH_XL)) begin
                            lineOkNext = 1'b1;
                            kindNext = `SBL_KIND_X;
                        end else if (rxD == `SBL_CH_SP && lineOkReg
                            && fieldReg != `SBL_FIELD_CNT) begin
                            fieldNext = 2'(fieldReg + 2'h1);
                            kindNext = `SBL_KIND_SP;
                        end else if (hv[4] && fieldReg == `SBL_FIELD_ADDR) begin
                            addrNext = {addrReg[27:0], hv[3:0]};
                            kindNext = `SBL_KIND_HEX;
                        end else if (hv[4] && fieldReg == `SBL_FIELD_CNT) begin
                            cntNext = {cntReg[27:0], hv[3:0]};
                            kindNext = `SBL_KIND_HEX;
                        end else begin
                            lineOkNext = 1'b0;
                            kindNext = `SBL_KIND_NONE;
                        end
                    end
                end
            end
            SBL_ST_CKSUM: begin
                if (timeout) begin
                    startMsg = 1'b1;
                    startSel = SBL_MSG_ERR;
                end else if (rxFire) begin
                    startMsg = 1'b1;
                    if (ckSum == 8'h00) begin
                        sumNext = 8'h00;
                        errNext = 1'b0;
                        suppNext = 1'b0;
                        remNext = cntReg[30:0];
                        if (cntReg[`SBL_DIR_BIT]) begin
                            startRet = cntReg[30:0] == 31'h0 ? SBL_ST_ULSUM : SBL_ST_ULRD;
                        end else begin
                            startRet = cntReg[30:0] == 31'h0 ? SBL_ST_LDSUM : SBL_ST_LOAD;
                        end
                    end else begin
                        startSel = SBL_MSG_ERR;
                    end
                end
            end
            SBL_ST_MSG: begin
                if (!pausedReg) begin
                    pushValid = 1'b1;
                    pushData = msgChar(msgSelReg, msgIdxReg);
                    if (pushReady) begin
                        msgIdxNext = 4'(msgIdxReg + 4'h1);
                        if (msgIdxReg == (msgSelReg == SBL_MSG_ERR ? `SBL_ERR_LAST
                            : `SBL_PROMPT_LAST)) begin
                            stateNext = retReg;
                        end
                    end
                end
            end
            SBL_ST_LOAD: begin
                if (timeout) begin
                    startMsg = 1'b1;
                    startSel = SBL_MSG_ERR;
                end else if (rxFire) begin
                    sumNext = ckSum;
                    dataNext = rxD;
                    errNext = errReg || rxByte.err;
                    stateNext = SBL_ST_LDWR;
                end
            end
            SBL_ST_LDWR: begin
                if (memAck) begin
                    errNext = errReg || memErr;
                    addrNext = addrReg + 32'h1;
                    remNext = remReg - 31'h1;
                    stateNext = remReg == `SBL_REM_LAST ? SBL_ST_LDSUM : SBL_ST_LOAD;
                end
            end
            SBL_ST_LDSUM: begin
                if (timeout) begin
                    startMsg = 1'b1;
                    startSel = SBL_MSG_ERR;
                end else if (rxFire) begin
                    startMsg = 1'b1;
                    startSel = (ckSum != 8'h00 || errReg || rxByte.err)
                        ? SBL_MSG_ERR : SBL_MSG_PROMPT;
                end
            end
            SBL_ST_ULRD: begin
                if (memAck) begin
                    dataNext = memRdata;
                    errNext = errReg || memErr;
                    stateNext = SBL_ST_ULSEND;
                end
            end
            SBL_ST_ULSEND, SBL_ST_ULSUM: begin
                // suppressed output still counts, so the stream stays framed
                pushData = stateReg == SBL_ST_ULSUM ? 8'(-sumReg) : dataReg;
                pushValid = !suppReg && !pausedReg;
                advance = suppReg || (pushValid && pushReady);
                if (advance && stateReg == SBL_ST_ULSEND) begin
                    sumNext = 8'(sumReg + dataReg);
                    addrNext = addrReg + 32'h1;
                    remNext = remReg - 31'h1;
                    stateNext = remReg == `SBL_REM_LAST ? SBL_ST_ULSUM : SBL_ST_ULRD;
                end else if (advance) begin
                    startMsg = 1'b1;
                    startSel = errReg ? SBL_MSG_ERR : SBL_MSG_PROMPT;
                end
            end
            default: begin
                stateNext = SBL_ST_LINE;
            end
        endcase
        if (isUnload(stateReg) && rxFire) begin
            errNext = errNext || rxByte.err;
            if (rxD == `SBL_CH_XOFF || rxD == `SBL_CH_XON) begin
                pausedNext = rxD == `SBL_CH_XOFF;
            end else if (rxD == `SBL_CH_CTLO) begin
                suppNext = !suppReg;
            end else if (rxD == `SBL_CH_CTLC) begin
                startMsg = 1'b1;
                startSel = SBL_MSG_ERR;
                startRet = SBL_ST_LINE;
            end
        end
        if (startMsg) begin
            stateNext = SBL_ST_MSG;
            msgSelNext = startSel;
            msgIdxNext = 4'h0;
            retNext = startRet;
            if (startRet == SBL_ST_LINE) begin
                // no byte is taken while a message goes out, so a held pause would lock up
                pausedNext = 1'b0;
                sumNext = 8'h00;
                addrNext = 32'h0;
                cntNext = 32'h0;
                suppNext = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateReg <= SBL_ST_LINE;
            retReg <= SBL_ST_LINE;
            msgSelReg <= SBL_MSG_PROMPT;
            msgIdxReg <= 4'h0;
            fieldReg <= `SBL_FIELD_CMD;
            kindReg <= `SBL_KIND_NONE;
            lineOkReg <= 1'b0;
            lastChReg <= 8'h00;
            sumReg <= 8'h00;
            dataReg <= 8'h00;
            addrReg <= 32'h0;
            cntReg <= 32'h0;
            tmrReg <= 32'h0;
            remReg <= 31'h0;
            errReg <= 1'b0;
            pausedReg <= 1'b0;
            suppReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            retReg <= retNext;
            msgSelReg <= msgSelNext;
            msgIdxReg <= msgIdxNext;
            fieldReg <= fieldNext;
            kindReg <= kindNext;
            lineOkReg <= lineOkNext;
            lastChReg <= lastChNext;
            sumReg <= sumNext;
            dataReg <= dataNext;
            addrReg <= addrNext;
            cntReg <= cntNext;
            tmrReg <= tmrNext;
            remReg <= remNext;
            errReg <= errNext;
            pausedReg <= pausedNext;
            suppReg <= suppNext;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_NO_ECHO_CKSUM: assert property (@(posedge clk) disable iff (sys_rst)
        stateReg == SBL_ST_CKSUM |-> !pushValid) else $error("checksum byte echoed");
    AST_NO_ECHO_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
        (stateReg inside {SBL_ST_LOAD, SBL_ST_LDWR, SBL_ST_LDSUM}) |-> !pushValid)
        else $error("output during load");
    AST_BAD_CMD: assert property (@(posedge clk) disable iff (sys_rst)
        stateReg == SBL_ST_CKSUM && rxFire && ckSum != 8'h00 && !timeout
        |=> stateReg == SBL_ST_MSG && msgSelReg == SBL_MSG_ERR && retReg == SBL_ST_LINE)
        else $error("bad command checksum not refused");
    AST_GOOD_CMD: assert property (@(posedge clk) disable iff (sys_rst)
        stateReg == SBL_ST_CKSUM && rxFire && ckSum == 8'h00 && !timeout
        |=> stateReg == SBL_ST_MSG && msgSelReg == SBL_MSG_PROMPT && retReg != SBL_ST_LINE)
        else $error("good command not prompted");
    AST_DIR_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
        memReqValid && memReqBits.we |-> !cntReg[`SBL_DIR_BIT])
        else $error("memory written during unload");
    AST_UL_SUM: assert property (@(posedge clk) disable iff (sys_rst)
        stateReg == SBL_ST_ULSUM && pushValid |-> 8'(pushData + sumReg) == 8'h00)
        else $error("wrong unload checksum");
    AST_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
        timeout |=> stateReg == SBL_ST_MSG && msgSelReg == SBL_MSG_ERR)
        else $error("deadline missed without abort");
    AST_COUNT_DOWN: assert property (@(posedge clk) disable iff (sys_rst)
        stateReg == SBL_ST_LDWR && memAck
        |=> remReg == $past(remReg) - 31'h1 && addrReg == $past(addrReg) + 32'h1)
        else $error("count or address not stepped");
    AST_FLOW_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        stateReg == SBL_ST_LINE && rxFire && rxD == `SBL_CH_CR |=> !pausedReg)
        else $error("flow control still active after carriage return");
    AST_LOAD_ERR: assert property (@(posedge clk) disable iff (sys_rst)
        stateReg == SBL_ST_LDSUM && rxFire && !timeout && (errReg || ckSum != 8'h00)
        |=> msgSelReg == SBL_MSG_ERR) else $error("load error not reported");

endmodule // sbl_binload

/* design/sbl_map.svh */
// constants for the serial binary load/unload command handler
`ifndef SBL_MAP_SVH
`define SBL_MAP_SVH

// ----------------------------------------------------------------------
// characters
// ----------------------------------------------------------------------
`define SBL_CH_CR 8'h0d
`define SBL_CH_LF 8'h0a
`define SBL_CH_RUB 8'h7f
`define SBL_CH_SP 8'h20
`define SBL_CH_XU 8'h58
`define SBL_CH_XL 8'h78
`define SBL_CH_CTLC 8'h03
`define SBL_CH_CTLO 8'h0f
`define SBL_CH_XON 8'h11
`define SBL_CH_XOFF 8'h13
`define SBL_CH_GT 8'h3e
`define SBL_CH_QM 8'h3f
`define SBL_CH_E 8'h45
`define SBL_CH_R 8'h52
`define SBL_CH_0 8'h30
`define SBL_CH_9 8'h39
`define SBL_CH_UA 8'h41
`define SBL_CH_UF 8'h46
`define SBL_CH_LA 8'h61
`define SBL_CH_LF_HEX 8'h66
`define SBL_HEX_TEN 8'h0a

// ----------------------------------------------------------------------
// command fields and messages
// ----------------------------------------------------------------------
`define SBL_DIR_BIT 31
`define SBL_FIELD_CMD 2'h0
`define SBL_FIELD_ADDR 2'h1
`define SBL_FIELD_CNT 2'h2
`define SBL_KIND_NONE 2'h0
`define SBL_KIND_HEX 2'h1
`define SBL_KIND_SP 2'h2
`define SBL_KIND_X 2'h3
`define SBL_PROMPT_LAST 4'h2
`define SBL_ERR_LAST 4'h8
`define SBL_REM_LAST 31'h1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SBL_TIMEOUT_S 64'd60
`define SBL_CLK_HZ 64'd40000000

`endif

/* design/sbl_pkg.sv */
// types shared by the serial binary load/unload command handler
package sbl_pkg;

    typedef enum logic [3:0] {
        SBL_ST_LINE = 4'b0000,
        SBL_ST_CKSUM = 4'b0001,
        SBL_ST_MSG = 4'b0010,
        SBL_ST_LOAD = 4'b0011,
        SBL_ST_LDWR = 4'b0100,
        SBL_ST_LDSUM = 4'b0101,
        SBL_ST_ULRD = 4'b0110,
        SBL_ST_ULSEND = 4'b0111,
        SBL_ST_ULSUM = 4'b1000
    } sbl_state_t;

    typedef enum logic {
        SBL_MSG_PROMPT = 1'b0,
        SBL_MSG_ERR = 1'b1
    } sbl_msg_t;

    typedef struct packed {
        logic [7:0] data;
        logic err;
    } sbl_rx_t;

    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [7:0] wdata;
    } sbl_mem_req_t;

endpackage

/* test/sbl_mem_model.sv */
// memory partner model answering the handler's byte requests
module sbl_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // request side
    input wire logic memReqValid,
    input wire sbl_pkg::sbl_mem_req_t memReqBits,
    input wire logic [1:0] ackDelay,
    output logic memAck,
    output logic memErr,
    output logic [7:0] memRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbl_pkg::*;
    logic [7:0] store [256];
    logic [1:0] waitCnt;
    int writes;
    assign memAck = memReqValid && (waitCnt == ackDelay);
    // one poisoned location lets the memory error path be reached
    assign memErr = memAck && memReqBits.addr[7:0] == 8'hff;
    // no stale data outside the ack cycle
    assign memRdata = memAck ? store[memReqBits.addr[7:0]] : ~store[memReqBits.addr[7:0]];
    initial begin
        writes = 0;
        for (int i = 0; i < 256; i++) begin
            store[i] = 8'(i * 7 + 3);
        end
    end
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitCnt <= 2'h0;
        end else if (memAck) begin
            waitCnt <= 2'h0;
            if (memReqBits.we) begin
                store[memReqBits.addr[7:0]] <= memReqBits.wdata;
                writes <= writes + 1;
            end
        end else if (memReqValid) begin
            waitCnt <= waitCnt + 2'h1;
        end
    end
endmodule // sbl_mem_model

/* test/sbl_binload_tb.sv */
// self-checking bench for the binary load/unload command handler
module sbl_binload_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sbl_pkg::*;
    logic clk, sys_rst, rxValid, rxReady, txValid, txReady, memReqValid, memAck, memErr, busy;
    logic [7:0] txData, memRdata;
    logic [1:0] ackDelay;
    logic lineErr;
    sbl_rx_t rxByte;
    sbl_mem_req_t memReqBits;
    logic [7:0] txQ [$];
    int n_fail = 0;
    int tests_run = 0;
    sbl_binload #(.TIMEOUT_CYC(32'd50)) dut (.clk(clk), .sys_rst(sys_rst), .rxValid(rxValid),
        .rxByte(rxByte), .rxReady(rxReady), .txValid(txValid), .txData(txData),
        .txReady(txReady), .memReqValid(memReqValid), .memReqBits(memReqBits),
        .memAck(memAck), .memErr(memErr), .memRdata(memRdata), .busy(busy));
    sbl_mem_model mem (.clk(clk), .sys_rst(sys_rst), .memReqValid(memReqValid),
        .memReqBits(memReqBits), .ackDelay(ackDelay), .memAck(memAck), .memErr(memErr),
        .memRdata(memRdata));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (txValid === 1'b1 && txReady === 1'b1) txQ.push_back(txData);
    end
    // --------------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    // bytes go out with one idle cycle between, so rxValid is never reasserted at once
    task automatic send_byte(input logic [7:0] b);
        int i;
        rxValid = 1'b1;
        rxByte = '{data: b, err: lineErr};
        for (i = 0; i < 400 && rxReady !== 1'b1; i++) @(negedge clk);
        if (i == 400) begin n_fail++; report_and_stop(); end
        @(negedge clk);
        rxValid = 1'b0;
        @(negedge clk);
    endtask
    task automatic expect_b(input string what, input logic [7:0] exp);
        int i;
        for (i = 0; i < 400 && txQ.size() == 0; i++) @(negedge clk);
        if (i == 400) begin n_fail++; report_and_stop(); end
        check8(what, exp, txQ.pop_front());
    endtask
    task automatic expect_tx(input string s);
        for (int k = 0; k < s.len(); k++) expect_b("txData", s[k]);
    endtask
    // command line, then its checksum plus a deliberate offset
    task automatic send_cmd(input string s, input logic [7:0] bad);
        logic [7:0] sum;
        sum = 8'h00;
        for (int k = 0; k < s.len(); k++) begin sum += s[k]; send_byte(s[k]); end
        send_byte(8'h0d);
        send_byte(8'(-sum) + bad);
        expect_tx(s);
    endtask
    // --------------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------------
    task automatic t_load_good();
        logic [7:0] d [3] = '{8'h11, 8'h13, 8'h03};
        send_cmd("X 10 3", 8'h00);
        expect_tx(">>>");
        foreach (d[k]) send_byte(d[k]);
        send_byte(8'hd9);
        expect_tx(">>>");
        check8("echo", 8'h00, 8'(txQ.size()));
        foreach (d[k]) check8("mem", d[k], mem.store[16 + k]);
        send_cmd("X 60 0", 8'h00);
        expect_tx(">>>");
        send_byte(8'h00);
        expect_tx(">>>");
        $display("test load_good done");
    endtask
    task automatic t_load_bad();
        int w;
        w = mem.writes;
        send_cmd("X 20 2", 8'h00);
        expect_tx(">>>");
        send_byte(8'h55);
        send_byte(8'h66);
        send_byte(8'h00);
        expect_tx("?ERR\r\n>>>");
        check8("writes", 8'h02, 8'(mem.writes - w));
        send_cmd("X 70 1", 8'h00);
        expect_tx(">>>");
        lineErr = 1'b1;
        send_byte(8'h12);
        lineErr = 1'b0;
        send_byte(8'hee);
        expect_tx("?ERR\r\n>>>");
        send_cmd("X ff 1", 8'h00);
        expect_tx(">>>");
        send_byte(8'h12);
        send_byte(8'hee);
        expect_tx("?ERR\r\n>>>");
        check8("writes", 8'h04, 8'(mem.writes - w));
        $display("test load_bad done");
    endtask
    task automatic t_cmd_bad();
        int w;
        w = mem.writes;
        send_cmd("X 30 1", 8'h01);
        expect_tx("?ERR\r\n>>>");
        repeat (20) @(negedge clk);
        check8("writes", 8'h00, 8'(mem.writes - w));
        check8("extra", 8'h00, 8'(txQ.size()));
        $display("test cmd_bad done");
    endtask
    task automatic t_unload();
        logic [7:0] a, b;
        a = mem.store[8'h40];
        b = mem.store[8'h41];
        ackDelay = 2'h2;
        send_cmd("X 40 80000002", 8'h00);
        txReady = 1'b0;
        repeat (30) @(negedge clk);
        txReady = 1'b1;
        expect_tx(">>>");
        expect_b("byte0", a);
        expect_b("byte1", b);
        expect_b("ulsum", 8'(-(a + b)));
        expect_tx(">>>");
        ackDelay = 2'h0;
        $display("test unload done");
    endtask
    task automatic t_timeout();
        string s = "X 50 1";
        for (int k = 0; k < s.len(); k++) send_byte(s[k]);
        send_byte(8'h0d);
        check8("busy", 8'h01, 8'(busy));
        expect_tx({s, "?ERR\r\n>>>"});
        check8("idle", 8'h00, 8'(busy));
        $display("test timeout done");
    endtask
    initial begin
        sys_rst = 1'b1;
        rxValid = 1'b0;
        rxByte = '0;
        txReady = 1'b1;
        ackDelay = 2'h0;
        lineErr = 1'b0;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        t_load_good();
        t_load_bad();
        t_cmd_bad();
        t_unload();
        t_timeout();
        report_and_stop();
    end
endmodule // sbl_binload_tb
